//--- rtl/lcd_segment_display_memory_driver.sv
// Function
// - Display memory is 19 bytes at data addresses 40H to 52H of bank 1, one byte per column.
// - With the bank select at 04H holding 01H, indirect accesses to 40H..52H reach the display memory.
// - With the bank select holding 00H, 40H..52H reach plain data memory instead.
// - Display memory is reached only indirectly through the second pointer, never directly.
// - The driver scans display memory by itself and follows every change without software.
// - A stored 1 turns its segment on and a stored 0 turns it off.
// - An option picks 19x2 at 1/2 duty, 19x3 at 1/3 duty or 18x4 at 1/4 duty.
// - With four commons the last segment line becomes the fourth common.
// - At 1/2 duty the third common line is not driven.
// - The driver clock is the source clock divided by a power of two from 2^2 to 2^8.
// - An option decides whether the display keeps running or turns off during halt.
// - An option picks 1/2 or 1/3 bias and the waveforms use the matching levels.
`timescale 1ns/1ps
`default_nettype none
module lcd_segment_display_memory_driver (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [lcd_pkg::ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic ack_o,
    output logic [31:0] dat_o,
    // Processor state
    input wire logic haltState,
    // Glass drive levels
    output lcd_pkg::lcdDrive_t lcdDrive
);
    import lcd_pkg::*;

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic [7:0] divMask(input logic [2:0] sel);
        logic [2:0] s;
        s = (sel > DIV_MAX_SEL) ? DIV_MAX_SEL : sel;
        divMask = 8'((9'h001 << ({1'b0, s} + {1'b0, DIV_MIN_LOG})) - 9'h001);
    endfunction

    function automatic logic [1:0] level(input logic bias3, input logic ph,
                                         input logic isCom, input logic act);
        logic [1:0] top;
        top = bias3 ? LVL_3 : LVL_2;
        if (isCom) begin
            if (act) level = ph ? LVL_0 : top;
            else level = bias3 ? (ph ? LVL_2 : LVL_1) : LVL_1;
        end else begin
            if (act) level = ph ? top : LVL_0;
            else level = bias3 ? (ph ? LVL_1 : LVL_2) : (ph ? LVL_0 : LVL_2);
        end
    endfunction

    // ----------------------------------------------------------------
    // Storage and address decode
    // ----------------------------------------------------------------
    logic [7:0] ramBankSelect;
    logic [7:0] indirectPointerSecond;
    logic [7:0] lcdOptions;
    logic [NSEG-1:0][7:0] dispMem;
    logic [NSEG-1:0][7:0] gpMem;
    logic [1:0] comIdx;
    logic phase;
    logic dispOn;
    logic [7:0] divCnt;
    logic req, wr, indAcc, inWin, toDisp, toGp, tick;
    logic [7:0] effAddr;
    logic [4:0] slot;
    logic [31:0] next_rdata;
    logic [1:0] duty;
    logic bias3;
    logic [1:0] lastCom;
    lcdDrive_t next_drive;

    assign req = cyc_i & stb_i & ~ack_o;
    assign wr = req & we_i & sel_i[0];
    assign indAcc = (adr_i == IDX_INDIRECT);
    assign effAddr = indAcc ? indirectPointerSecond : adr_i;
    assign inWin = (effAddr >= DISP_LO) && (effAddr <= DISP_HI);
    assign toDisp = indAcc & inWin & (ramBankSelect == BANK_DISPLAY);
    assign toGp = inWin & ~toDisp;
    assign slot = 5'(effAddr - DISP_LO);
    assign duty = lcdOptions[OPT_DUTY_LO +: 2];
    assign bias3 = lcdOptions[OPT_BIAS3];
    assign lastCom = (duty == DUTY_HALF) ? 2'h1 : (duty == DUTY_THIRD) ? 2'h2 : 2'h3;
    assign dispOn = ~haltState | lcdOptions[OPT_HALT_KEEP];

    // ----------------------------------------------------------------
    // Bus answer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) ack_o <= 1'b0;
        else ack_o <= req;
    end

    always_comb begin
        next_rdata = '0;
        if (toDisp) begin
            next_rdata[7:0] = dispMem[slot];
        end else if (toGp) begin
            next_rdata[7:0] = gpMem[slot];
        end else if (effAddr == IDX_BANK) begin
            next_rdata[7:0] = ramBankSelect;
        end else if (effAddr == IDX_POINTER) begin
            next_rdata[7:0] = indirectPointerSecond;
        end else if (effAddr == IDX_OPTIONS) begin
            next_rdata[7:0] = lcdOptions;
        end else if (effAddr == IDX_STATUS) begin
            next_rdata[3:0] = {phase, dispOn, comIdx};
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) dat_o <= '0;
        else if (req & ~we_i) dat_o <= next_rdata;
    end

    // ----------------------------------------------------------------
    // Registers and memories
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ramBankSelect <= BANK_RESET;
            indirectPointerSecond <= POINTER_RESET;
            lcdOptions <= OPT_RESET;
        end else if (wr) begin
            if (effAddr == IDX_BANK) ramBankSelect <= dat_i[7:0];
            else if (effAddr == IDX_POINTER) indirectPointerSecond <= dat_i[7:0];
            else if (effAddr == IDX_OPTIONS) lcdOptions <= dat_i[7:0] & OPT_MASK;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) dispMem <= '0;
        else if (wr & toDisp) dispMem[slot] <= dat_i[7:0];
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) gpMem <= '0;
        else if (wr & toGp) gpMem[slot] <= dat_i[7:0];
    end

    // ----------------------------------------------------------------
    // Driver clock and scan
    // ----------------------------------------------------------------
    assign tick = ((divCnt & divMask(lcdOptions[OPT_DIV_LO +: 3])) ==
                   divMask(lcdOptions[OPT_DIV_LO +: 3]));

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) divCnt <= '0;
        else divCnt <= divCnt + 8'h01;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            comIdx <= '0;
            phase <= 1'b0;
        end else if (tick) begin
            if (comIdx >= lastCom) begin
                comIdx <= '0;
                phase <= ~phase;
            end else begin
                comIdx <= comIdx + 2'h1;
            end
        end
    end

    always_comb begin
        next_drive = '0;
        if (dispOn) begin
            for (int c = 0; c < 3; c++) begin
                if (2'(c) <= lastCom)
                    next_drive.com[c] = level(bias3, phase, 1'b1, comIdx == 2'(c));
            end
            for (int s = 0; s < NSEG; s++) begin
                next_drive.seg[s] = level(bias3, phase, 1'b0, dispMem[s][comIdx]);
            end
            if (lastCom == 2'h3)
                next_drive.seg[NSEG-1] = level(bias3, phase, 1'b1, comIdx == 2'h3);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) lcdDrive <= '0;
        else lcdDrive <= next_drive;
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [7:0] gap;
    logic gapClean;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            gap <= '0;
            gapClean <= 1'b1;
        end else begin
            gap <= tick ? 8'h00 : gap + 8'h01;
            if (wr && effAddr == IDX_OPTIONS) gapClean <= 1'b0;
            else if (tick) gapClean <= 1'b1;
        end
    end

    chk_disp_write: assert property (@(posedge clk_sys) disable iff (rst)
        wr && toDisp |=> dispMem[$past(slot)] == $past(dat_i[7:0]))
        else $error("display write lost");
    chk_bank_zero_gp: assert property (@(posedge clk_sys) disable iff (rst)
        wr && inWin && ramBankSelect == BANK_RESET |=> $stable(dispMem))
        else $error("bank 0 write reached display memory");
    chk_direct_blocked: assert property (@(posedge clk_sys) disable iff (rst)
        wr && !indAcc |=> $stable(dispMem))
        else $error("direct write reached display memory");
    chk_com_order: assert property (@(posedge clk_sys) disable iff (rst)
        tick && comIdx < lastCom && $stable(lcdOptions) |=> comIdx == $past(comIdx) + 2'h1)
        else $error("common order broken");
    chk_seg_on_bit: assert property (@(posedge clk_sys) disable iff (rst)
        dispOn && dispMem[0][comIdx] && !phase |=> lcdDrive.seg[0] == LVL_0)
        else $error("segment on level wrong");
    chk_halt_off: assert property (@(posedge clk_sys) disable iff (rst)
        haltState && !lcdOptions[OPT_HALT_KEEP] |=> lcdDrive == '0)
        else $error("display not off in halt");
    chk_half_duty: assert property (@(posedge clk_sys) disable iff (rst)
        duty == DUTY_HALF |=> lcdDrive.com[2] == LVL_0)
        else $error("third common driven at half duty");
    chk_four_com: assert property (@(posedge clk_sys) disable iff (rst)
        dispOn && lastCom == 2'h3 && comIdx == 2'h3 && !phase && bias3
        |=> lcdDrive.seg[NSEG-1] == LVL_3)
        else $error("last segment not acting as common");
    chk_div_period: assert property (@(posedge clk_sys) disable iff (rst)
        tick && gapClean |-> gap == divMask(lcdOptions[OPT_DIV_LO +: 3]))
        else $error("driver clock period wrong");
    chk_half_bias: assert property (@(posedge clk_sys) disable iff (rst)
        !bias3 |=> lcdDrive.com[0] != LVL_3)
        else $error("top level used at half bias");
    chk_bus_ack: assert property (@(posedge clk_sys) disable iff (rst)
        req |=> ack_o ##1 !ack_o)
        else $error("ack not a one cycle answer");
    chk_ack_only_req: assert property (@(posedge clk_sys) disable iff (rst)
        !req |=> !ack_o)
        else $error("ack without a request");
    chk_bank_write: assert property (@(posedge clk_sys) disable iff (rst)
        wr && effAddr == IDX_BANK |=> ramBankSelect == $past(dat_i[7:0]))
        else $error("bank select write lost");
    chk_bank_read: assert property (@(posedge clk_sys) disable iff (rst)
        req && !we_i && effAddr == IDX_BANK |=> dat_o[7:0] == $past(ramBankSelect))
        else $error("bank select read wrong");
    chk_disp_read: assert property (@(posedge clk_sys) disable iff (rst)
        req && !we_i && toDisp |=> dat_o[7:0] == $past(dispMem[slot]))
        else $error("display read wrong");
    chk_gp_write: assert property (@(posedge clk_sys) disable iff (rst)
        wr && toGp |=> gpMem[$past(slot)] == $past(dat_i[7:0]))
        else $error("data memory write lost");
    chk_gp_read: assert property (@(posedge clk_sys) disable iff (rst)
        req && !we_i && toGp |=> dat_o[7:0] == $past(gpMem[slot]))
        else $error("data memory read wrong");
    chk_ptr_write: assert property (@(posedge clk_sys) disable iff (rst)
        wr && effAddr == IDX_POINTER |=> indirectPointerSecond == $past(dat_i[7:0]))
        else $error("pointer write lost");
    chk_options_read: assert property (@(posedge clk_sys) disable iff (rst)
        req && !we_i && effAddr == IDX_OPTIONS |=> dat_o[7:0] == $past(lcdOptions))
        else $error("options read wrong");
    chk_status_read: assert property (@(posedge clk_sys) disable iff (rst)
        req && !we_i && effAddr == IDX_STATUS |=> dat_o[3:0] == $past({phase, dispOn, comIdx}))
        else $error("status read wrong");
    chk_run_drive: assert property (@(posedge clk_sys) disable iff (rst)
        !haltState |=> lcdDrive.com != '0)
        else $error("commons idle while running");
    chk_seg_off_bit: assert property (@(posedge clk_sys) disable iff (rst)
        dispOn && !dispMem[0][comIdx] && !phase |=> lcdDrive.seg[0] == LVL_2)
        else $error("segment off level wrong");
    chk_last_seg: assert property (@(posedge clk_sys) disable iff (rst)
        dispOn && lastCom != 2'h3 && dispMem[NSEG-1][comIdx] && !phase
        |=> lcdDrive.seg[NSEG-1] == LVL_0)
        else $error("last segment not acting as segment");
    chk_tick_rate: assert property (@(posedge clk_sys) disable iff (rst)
        tick |=> !tick)
        else $error("driver clock too fast");
    chk_com_sel_level: assert property (@(posedge clk_sys) disable iff (rst)
        dispOn && !phase && comIdx == 2'h0 && bias3 |=> lcdDrive.com[0] == LVL_3)
        else $error("selected common level wrong");
    chk_half_bias_seg: assert property (@(posedge clk_sys) disable iff (rst)
        !bias3 |=> lcdDrive.seg[0] != LVL_3)
        else $error("top level on segment at half bias");
    chk_com_hold: assert property (@(posedge clk_sys) disable iff (rst)
        !tick |=> comIdx == $past(comIdx))
        else $error("common moved without a tick");
    chk_com_wrap: assert property (@(posedge clk_sys) disable iff (rst)
        tick && comIdx >= lastCom |=> comIdx == 2'h0 && phase != $past(phase))
        else $error("frame wrap wrong");

    cov_disp_write: cover property (@(posedge clk_sys) disable iff (rst) wr && toDisp);
    cov_four_com: cover property (@(posedge clk_sys) disable iff (rst)
        tick && lastCom == 2'h3 && comIdx == 2'h3);
    cov_halt_keep: cover property (@(posedge clk_sys) disable iff (rst)
        haltState && dispOn);
    cov_gp_write: cover property (@(posedge clk_sys) disable iff (rst) wr && toGp);
    cov_frame_wrap: cover property (@(posedge clk_sys) disable iff (rst)
        tick && comIdx >= lastCom && phase);
endmodule // lcd_segment_display_memory_driver
`default_nettype wire

//--- shared/lcd_pkg.sv
`default_nettype none
package lcd_pkg;
    // ----------------------------------------------------------------
    // Register word indices (byte address = 4 * index)
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_INDIRECT = 8'h00;
    localparam logic [7:0] IDX_POINTER = 8'h01;
    localparam logic [7:0] IDX_BANK = 8'h04;
    localparam logic [7:0] IDX_OPTIONS = 8'h60;
    localparam logic [7:0] IDX_STATUS = 8'h61;
    localparam logic [7:0] DISP_LO = 8'h40;
    localparam logic [7:0] DISP_HI = 8'h52;
    localparam logic [7:0] BANK_DISPLAY = 8'h01;
    localparam logic [7:0] BANK_RESET = 8'h00;
    localparam logic [7:0] POINTER_RESET = 8'h00;
    localparam int NSEG = 19;
    localparam int ADR_W = 8;
    // ----------------------------------------------------------------
    // Option register fields
    // ----------------------------------------------------------------
    localparam int OPT_DUTY_LO = 0;
    localparam int OPT_BIAS3 = 2;
    localparam int OPT_HALT_KEEP = 3;
    localparam int OPT_DIV_LO = 4;
    localparam logic [7:0] OPT_RESET = 8'h00;
    localparam logic [7:0] OPT_MASK = 8'h7F;
    localparam logic [1:0] DUTY_HALF = 2'h0;
    localparam logic [1:0] DUTY_THIRD = 2'h1;
    localparam logic [2:0] DIV_MAX_SEL = 3'h6;
    localparam logic [2:0] DIV_MIN_LOG = 3'h2;
    // ----------------------------------------------------------------
    // Drive levels, in steps of the bias fraction
    // ----------------------------------------------------------------
    localparam logic [1:0] LVL_0 = 2'h0;
    localparam logic [1:0] LVL_1 = 2'h1;
    localparam logic [1:0] LVL_2 = 2'h2;
    localparam logic [1:0] LVL_3 = 2'h3;
    typedef struct packed {
        logic [2:0][1:0] com;
        logic [NSEG-1:0][1:0] seg;
    } lcdDrive_t;
endpackage
`default_nettype wire

//--- verification/lcd_glass_model.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_glass_model (
    // Clock and drive levels
    input wire logic clk_sys,
    input wire lcd_pkg::lcdDrive_t lcdDrive,
    // Glass setup
    input wire logic bias3,
    input wire logic [2:0] comCount,
    input wire logic clear,
    // Segments seen lit since clear
    output logic [3:0][18:0] seen
);
    import lcd_pkg::*;
    function automatic logic [1:0] dif(input logic [1:0] a, input logic [1:0] b);
        return (a > b) ? a - b : b - a;
    endfunction
    function automatic logic [1:0] comLvl(input int c);
        return (c < 3) ? lcdDrive.com[c[1:0]] : lcdDrive.seg[18];
    endfunction
    // A segment lights when it sees full drive against a wired common
    always_ff @(posedge clk_sys) begin
        for (int c = 0; c < 4; c++) begin
            for (int s = 0; s < NSEG; s++) begin
                if (clear) begin
                    seen[c][s] <= 1'b0;
                end else if (c < comCount && dif(comLvl(c), lcdDrive.seg[s])
                             == (bias3 ? LVL_3 : LVL_2)) begin
                    seen[c][s] <= 1'b1;
                end
            end
        end
    end
endmodule // lcd_glass_model
`default_nettype wire

//--- verification/lcd_segment_display_memory_driver_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_segment_display_memory_driver_tb;
    import lcd_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [ADR_W-1:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    logic haltState = 1'b0;
    logic clear = 1'b0;
    logic [7:0] opts = 8'h00;
    logic ack_o;
    logic [31:0] dat_o;
    lcdDrive_t lcdDrive;
    logic [3:0][18:0] seen;
    logic [2:0] comCount;
    logic [7:0] cfgs [7] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h0E};
    int fails = 0;
    int samples_checked = 0;
    assign comCount = opts[1] ? 3'h4 : (opts[0] ? 3'h3 : 3'h2);
    always #25 clk_sys = ~clk_sys;
    lcd_segment_display_memory_driver i_dut (.clk_sys(clk_sys), .rst(rst), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .ack_o(ack_o), .dat_o(dat_o), .haltState(haltState), .lcdDrive(lcdDrive));
    lcd_glass_model i_glass (.clk_sys(clk_sys), .lcdDrive(lcdDrive), .bias3(opts[OPT_BIAS3]),
        .comCount(comCount), .clear(clear), .seen(seen));
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [45:0] exp, input logic [45:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // --------------------------------------------------------------
    // Wishbone classic cycles
    // --------------------------------------------------------------
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'h1;
        dat_i <= {24'h00_0000, d};
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        q = dat_o[7:0];
        chk("ack", 46'h1, {45'h0, ack_o});
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(what, {38'h0, exp}, {38'h0, q});
    endtask
    // Scan a few frames and compare the lit map of columns 0, 1 and 18
    task automatic show(input logic [7:0] o, input logic h);
        logic [11:0] exp;
        logic [11:0] got;
        int nc;
        wr(IDX_OPTIONS, o);
        opts <= o;
        nc = o[1] ? 4 : (o[0] ? 3 : 2);
        haltState <= h;
        clear <= 1'b1;
        @(posedge clk_sys);
        clear <= 1'b0;
        repeat (80) @(posedge clk_sys);
        for (int c = 0; c < 4; c++) begin
            exp[3*c +: 3] = {c == 0 && nc < 4, c < nc && 8'h04 >> c & 1, c < nc && 8'h0B >> c & 1};
            got[3*c +: 3] = {seen[c][18], seen[c][1], seen[c][0]};
        end
        chk("lit map", {34'h0, exp}, {34'h0, got});
        if (nc == 2) chk("third common", 46'h0, {44'h0, lcdDrive.com[2]});
        haltState <= 1'b0;
    endtask
    task automatic period(input logic [2:0] n);
        logic [5:0] prev;
        int k;
        wr(IDX_OPTIONS, {1'b0, n, 4'h1});
        repeat (3) begin
            prev = lcdDrive.com;
            k = 0;
            do begin
                @(posedge clk_sys);
                k++;
            end while (lcdDrive.com === prev && k < 600);
        end
        chk("common period", 46'(1 << ((n == 3'h7 ? 6 : n) + 2)), 46'(k));
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        $display("ERROR watchdog expected done seen timeout");
        end_of_test();
    end
    initial begin
        logic [7:0] q;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rd("bank reset", IDX_BANK, BANK_RESET);
        rd("pointer reset", IDX_POINTER, POINTER_RESET);
        rd("unmapped", 8'h7F, 8'h00);
        wr(IDX_OPTIONS, 8'hFF);
        rd("options", IDX_OPTIONS, OPT_MASK);
        $display("Test registers done");
        wr(IDX_POINTER, DISP_LO);
        wr(IDX_INDIRECT, 8'h3C);
        rd("plain direct", DISP_LO, 8'h3C);
        wr(IDX_BANK, BANK_DISPLAY);
        wr(IDX_INDIRECT, 8'h0B);
        wr(IDX_POINTER, 8'h41);
        wr(IDX_INDIRECT, 8'h04);
        wr(IDX_POINTER, DISP_HI);
        wr(IDX_INDIRECT, 8'h01);
        rd("display indirect", IDX_INDIRECT, 8'h01);
        rd("plain kept", DISP_LO, 8'h3C);
        wr(DISP_LO, 8'hFF);
        $display("Test memory map done");
        for (int i = 0; i < 7; i++) show(cfgs[i], i == 6);
        wr(IDX_BANK, BANK_RESET);
        wr(IDX_POINTER, DISP_LO);
        wr(IDX_INDIRECT, 8'h00);
        show(8'h01, 1'b0);
        $display("Test scan done");
        wr(IDX_OPTIONS, 8'h01);
        haltState <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk("halt off", 46'h0, lcdDrive);
        bus(1'b0, IDX_STATUS, 8'h00, q);
        chk("status off", 46'h0, {45'h0, q[2]});
        haltState <= 1'b0;
        bus(1'b0, IDX_STATUS, 8'h00, q);
        chk("status on", 46'h1, {45'h0, q[2]});
        for (int n = 0; n < 8; n++) period(3'(n));
        $display("Test divider done");
        end_of_test();
    end
endmodule // lcd_segment_display_memory_driver_tb
`default_nettype wire
